//--- anmr_regs.sv
// APB register bank: autoneg expansion, next pages, master/slave status, indirect MMD access
//
// Operation
// - Parallel detection fault sets expansion bit 4; a read clears it.
// - Expansion bit 3 shows partner next-page ability, read-only.
// - Expansion bit 2 shows local next-page support, resets to one.
// - Expansion bit 1 sets on new page arrival; a read clears it.
// - Expansion bit 0 shows partner negotiation ability, meaningful only with negotiation on.
// - Register 7 holds transmit page; bit 15 marks more pages; code resets 0x1.
// - Next page bit 13 selects message page or unformatted page.
// - Bits 10:0 are message code or unformatted code by page type.
// - Bit 12 second acknowledge, writable in transmit, read-only in receive.
// - Bit 11 toggle is read-only, inverse of previous exchanged toggle.
// - Received page lands in read-only register 0x8, same layout, zero reset.
// - Master/slave bit 15 flags configuration fault, cleared by read.
// - Master/slave bit 14 reports resolved role, one for master.
// - Bits 13 and 12 show local and remote receiver OK, reset zero; the code passes local_rx_ok and remote_rx_ok through unregistered.
// - Bits 11 and 10 show gigabit capability indications, reset zero; the code passes gig_fd_adv and lp_gig_hd through unregistered.
// - Bits 7:0 count idle errors since last read; reads restart counting.
// - Address function steers register 0xE to chosen MMD address register.
// - Data functions steer register 0xE to addressed register in chosen MMD.
// - Control register 0xD fields are write-only; bits 13:5 read zero.
// - Register 0xE is address register or data register by function code.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`include "anmr_cfg.svh"

module anmr_regs
  import anmr_pkg::*;
(
  input  wire logic        pclk,           // System clock, 20 MHz
  input  wire logic        presetn,        // Asynchronous reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB access phase
  input  wire logic        pwrite,         // APB direction, high for write
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  input  wire logic [3:0]  pstrb,          // APB write byte lanes
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error, unmapped address
  input  wire logic        pd_fault_det,   // Parallel detection fault pulse
  input  wire logic        lp_np_able,     // Partner is next-page able
  input  wire logic        an_enable,      // Auto-negotiation enabled
  input  wire logic        lp_an_able,     // Partner can auto-negotiate
  input  wire logic        rx_page_valid,  // New page received pulse
  input  wire logic [15:0] rx_page_data,   // Received page word
  input  wire logic        tx_page_sent,   // Local next page exchanged pulse
  input  wire logic        ms_fault_det,   // Master/slave config fault pulse
  input  wire logic        ms_master,      // Resolved role, high for master
  input  wire logic        local_rx_ok,    // Local receiver OK
  input  wire logic        remote_rx_ok,   // Remote receiver OK
  input  wire logic        gig_fd_adv,     // Gigabit full-duplex advertised
  input  wire logic        lp_gig_hd,      // Partner gigabit half-duplex able
  input  wire logic        idle_err,       // Idle error pulse
  output logic      [15:0] tx_next_page,   // Next page word to transmit
  output logic             tx_page_loaded  // Pulse after software writes the next page
);

  // ======================================================================
  // Decoding helpers
  function automatic anmr_sel_t anmr_decode(input logic [7:0] addr);
    if (addr[1:0] != 2'h0)
    begin
      return SEL_NONE;
    end
    case (addr[7:2])
      `ANMR_IDX_EXP: return SEL_EXP;
      `ANMR_IDX_NPT: return SEL_NPT;
      `ANMR_IDX_NPR: return SEL_NPR;
      `ANMR_IDX_MSS: return SEL_MSS;
      `ANMR_IDX_IAC: return SEL_IAC;
      `ANMR_IDX_IAD: return SEL_IAD;
      default:       return SEL_NONE;
    endcase
  endfunction

  function automatic logic [1:0] anmr_mmd_index(input logic [4:0] dev);
    case (dev)
      `ANMR_DEV_MMD1: return 2'h0;
      `ANMR_DEV_MMD3: return 2'h1;
      `ANMR_DEV_MMD7: return 2'h2;
      default:        return `ANMR_DEV_NONE;
    endcase
  endfunction

  function automatic logic [15:0] anmr_merge(input logic [15:0] old, input logic [15:0] nw,
                                             input logic [15:0] keep);
    return (old & ~keep) | (nw & keep);
  endfunction

  // ======================================================================
  // Bus phase decoding
  anmr_sel_t   sel;
  logic        setup;
  logic        rd_take;
  logic        wr_take;
  logic [15:0] lane_mask;
  logic [15:0] wdata;

  assign sel       = anmr_decode(paddr);
  assign setup     = psel & ~penable;
  assign rd_take   = setup & ~pwrite;
  assign wr_take   = psel & penable & pwrite & pready;
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata     = pwdata[15:0];

  // ======================================================================
  // Expansion status
  logic pd_fault_q;
  logic page_rx_q;

  // sticky fault, read clears, set wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pd_fault_q <= 1'b0;
    else if (pd_fault_det)
      pd_fault_q <= 1'b1;
    else if (rd_take && sel == SEL_EXP)
      pd_fault_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      page_rx_q <= 1'b0;
    else if (rx_page_valid)
      page_rx_q <= 1'b1;
    else if (rd_take && sel == SEL_EXP)
      page_rx_q <= 1'b0;
  end

  logic [15:0] exp_word;

  always_comb
  begin
    exp_word = 16'h0000;
    exp_word[`ANMR_EXP_PD_FAULT] = pd_fault_q;
    exp_word[`ANMR_EXP_LP_NP]    = lp_np_able;
    exp_word[`ANMR_EXP_LOC_NP]   = `ANMR_LOC_NP_ABLE;
    exp_word[`ANMR_EXP_PAGE_RX]  = page_rx_q;
    exp_word[`ANMR_EXP_LP_AN]    = lp_an_able & an_enable;
  end

  // ======================================================================
  // Next page transmit and receive
  logic [15:0] npt_d;
  logic [15:0] npr_q;

  always_comb
  begin
    npt_d = tx_next_page;
    // more-pages, type, second_acknowledge and code writable; fields kept as written
    if (wr_take && sel == SEL_NPT)
    begin
      npt_d = anmr_merge(tx_next_page, wdata, `ANMR_NPT_RW_MASK & lane_mask);
    end
    // toggle flips once per exchanged page
    if (tx_page_sent)
    begin
      npt_d[`ANMR_NP_TOGGLE] = ~tx_next_page[`ANMR_NP_TOGGLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_next_page <= `ANMR_NPT_RESET;
    else
      tx_next_page <= npt_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tx_page_loaded <= 1'b0;
    else
      tx_page_loaded <= wr_take && sel == SEL_NPT;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      npr_q <= `ANMR_NPR_RESET;
    else if (rx_page_valid)
      npr_q <= rx_page_data & `ANMR_NPR_MASK;
  end

  // ======================================================================
  // Master/slave status
  logic        ms_fault_q;
  logic [7:0]  idle_cnt_q;
  logic [15:0] mss_word;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ms_fault_q <= 1'b0;
    else if (ms_fault_det)
      ms_fault_q <= 1'b1;
    else if (rd_take && sel == SEL_MSS)
      ms_fault_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_cnt_q <= 8'h00;
    else if (rd_take && sel == SEL_MSS)
      idle_cnt_q <= {7'h00, idle_err};
    else if (idle_err && idle_cnt_q != `ANMR_IDLE_MAX)
      idle_cnt_q <= idle_cnt_q + 8'h01;
  end

  always_comb
  begin
    mss_word = 16'h0000;
    mss_word[`ANMR_MSS_FAULT]  = ms_fault_q;
    mss_word[`ANMR_MSS_MASTER] = ms_master;
    mss_word[`ANMR_MSS_LOC_RX] = local_rx_ok;
    mss_word[`ANMR_MSS_REM_RX] = remote_rx_ok;
    mss_word[`ANMR_MSS_GIG_FD] = gig_fd_adv;
    mss_word[`ANMR_MSS_LP_GIG] = lp_gig_hd;
    mss_word[7:0]              = idle_cnt_q;
  end

  // ======================================================================
  // Indirect access control
  anmr_func_t  func_q;
  logic [4:0]  device_space_select_q;
  logic [1:0]  mmd_idx;
  logic        mmd_ok;

  // function and device fields taken from software writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      func_q  <= FN_ADDR;
      device_space_select_q <= 5'h00;
    end
    else if (wr_take && sel == SEL_IAC)
    begin
      if (pstrb[1])
        func_q <= anmr_func_t'(wdata[`ANMR_IAC_FUNC_HI:`ANMR_IAC_FUNC_LO]);
      if (pstrb[0])
        device_space_select_q <= wdata[4:0];
    end
  end

  assign mmd_idx = anmr_mmd_index(device_space_select_q);
  assign mmd_ok  = mmd_idx != `ANMR_DEV_NONE;

  // ======================================================================
  // MMD address registers and data storage
  logic [15:0] mmd_addr_q [0:2];
  logic [15:0] mmd_mem_q  [0:2][0:`ANMR_MMD_WORDS-1];
  logic [15:0] addr_sel;
  logic [2:0]  word_sel;
  logic        iad_wr;
  logic        iad_rd;

  assign iad_wr   = wr_take && sel == SEL_IAD && mmd_ok;
  assign iad_rd   = rd_take && sel == SEL_IAD && mmd_ok;
  assign addr_sel = mmd_ok ? mmd_addr_q[mmd_idx] : 16'h0000;
  assign word_sel = addr_sel[2:0];

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_mmd
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          mmd_addr_q[g] <= 16'h0000;
        else if (iad_wr && mmd_idx == 2'(g))
        begin
          // address function writes the address register
          if (func_q == FN_ADDR)
            mmd_addr_q[g] <= anmr_merge(mmd_addr_q[g], wdata, lane_mask);
          else if (func_q == FN_INC_RW || func_q == FN_INC_WR)
            mmd_addr_q[g] <= mmd_addr_q[g] + 16'h0001;
        end
        // increment after a read in read-write mode
        else if (iad_rd && mmd_idx == 2'(g) && func_q == FN_INC_RW)
          mmd_addr_q[g] <= mmd_addr_q[g] + 16'h0001;
      end
    end
  endgenerate

  // data functions write the addressed word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int d = 0; d < 3; d++)
        for (int w = 0; w < `ANMR_MMD_WORDS; w++)
          mmd_mem_q[d][w] <= 16'h0000;
    end
    else if (iad_wr && func_q != FN_ADDR)
      mmd_mem_q[mmd_idx][word_sel] <= anmr_merge(mmd_mem_q[mmd_idx][word_sel], wdata, lane_mask);
  end

  logic [15:0] iad_word;

  // address or data view by function
  always_comb
  begin
    iad_word = 16'h0000;
    if (mmd_ok)
      iad_word = (func_q == FN_ADDR) ? addr_sel : mmd_mem_q[mmd_idx][word_sel];
  end

  // ======================================================================
  // Read mux and APB answer
  logic [15:0] rd_word;

  always_comb
  begin
    rd_word = 16'h0000;
    unique case (sel)
      SEL_EXP:  rd_word = exp_word;
      SEL_NPT:  rd_word = tx_next_page;
      SEL_NPR:  rd_word = npr_q;
      SEL_MSS:  rd_word = mss_word;
      SEL_IAC:  rd_word = 16'h0000;
      SEL_IAD:  rd_word = iad_word;
      SEL_NONE: rd_word = 16'h0000;
    endcase
  end

  // Read data captured at the setup edge, together with clear-on-read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (setup)
      prdata <= rd_take ? {16'h0000, rd_word} : 32'h00000000;
  end

  // One wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= setup;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= setup && sel == SEL_NONE;
  end

endmodule

//--- anmr_cfg.svh
// Offsets, field positions and reset values of the autoneg next-page and indirect-access register bank
`ifndef ANMR_CFG_SVH
`define ANMR_CFG_SVH

// ======================================================================
// Register indices (byte address is four times the index)
`define ANMR_IDX_EXP      6'h06
`define ANMR_IDX_NPT      6'h07
`define ANMR_IDX_NPR      6'h08
`define ANMR_IDX_MSS      6'h0A
`define ANMR_IDX_IAC      6'h0D
`define ANMR_IDX_IAD      6'h0E

// ======================================================================
// Expansion status fields
`define ANMR_EXP_PD_FAULT 4
`define ANMR_EXP_LP_NP    3
`define ANMR_EXP_LOC_NP   2
`define ANMR_EXP_PAGE_RX  1
`define ANMR_EXP_LP_AN    0
`define ANMR_LOC_NP_ABLE  1'b1

// ======================================================================
// Next page fields and reset values
`define ANMR_NP_MORE      15
`define ANMR_NP_MSG       13
`define ANMR_NP_SECOND_ACKNOWLEDGE      12
`define ANMR_NP_TOGGLE    11
`define ANMR_NPT_RESET    16'h0001
`define ANMR_NPR_RESET    16'h0000
`define ANMR_NPT_RW_MASK  16'hB7FF
`define ANMR_NPR_MASK     16'hBFFF

// ======================================================================
// Master/slave status and idle error counter
`define ANMR_IDLE_MAX     8'hFF
`define ANMR_MSS_FAULT    15
`define ANMR_MSS_MASTER   14
`define ANMR_MSS_LOC_RX   13
`define ANMR_MSS_REM_RX   12
`define ANMR_MSS_GIG_FD   11
`define ANMR_MSS_LP_GIG   10

// ======================================================================
// Indirect access control fields and device codes
`define ANMR_IAC_FUNC_HI  15
`define ANMR_IAC_FUNC_LO  14
`define ANMR_DEV_MMD1     5'h01
`define ANMR_DEV_MMD3     5'h03
`define ANMR_DEV_MMD7     5'h07
`define ANMR_DEV_NONE     2'h3
`define ANMR_MMD_WORDS    8

`endif

//--- anmr_pkg.sv
// Types shared by the autoneg next-page and indirect-access register bank
package anmr_pkg;

  // Register select, one bit per decoded register
  typedef enum logic [6:0] {
    SEL_EXP  = 7'b0000001,
    SEL_NPT  = 7'b0000010,
    SEL_NPR  = 7'b0000100,
    SEL_MSS  = 7'b0001000,
    SEL_IAC  = 7'b0010000,
    SEL_IAD  = 7'b0100000,
    SEL_NONE = 7'b1000000
  } anmr_sel_t;

  // Indirect access function codes
  typedef enum logic [1:0] {
    FN_ADDR   = 2'h0,
    FN_DATA   = 2'h1,
    FN_INC_RW = 2'h2,
    FN_INC_WR = 2'h3
  } anmr_func_t;

endpackage

//--- anmr_regs_chk.sv
// Port-level assertions for the autoneg next-page and indirect-access register bank
`timescale 1ns/1ps
module anmr_regs_chk
(
  input wire logic        pclk,           // Clock
  input wire logic        presetn,        // Reset, active low
  input wire logic        psel,           // Select
  input wire logic        penable,        // Access phase
  input wire logic        pwrite,         // Direction
  input wire logic [7:0]  paddr,          // Address
  input wire logic [31:0] pwdata,         // Write data
  input wire logic [3:0]  pstrb,          // Lanes
  input wire logic [31:0] prdata,         // Read data
  input wire logic        pready,         // Ready
  input wire logic        pslverr,        // Error
  input wire logic        lp_np_able,     // Partner next page
  input wire logic        an_enable,      // Negotiation on
  input wire logic        lp_an_able,     // Partner negotiates
  input wire logic        tx_page_sent,   // Page exchanged
  input wire logic        ms_master,      // Role
  input wire logic        local_rx_ok,    // Local receiver
  input wire logic        remote_rx_ok,   // Remote receiver
  input wire logic        gig_fd_adv,     // Gigabit full duplex
  input wire logic        lp_gig_hd,      // Partner gigabit half
  input wire logic [15:0] tx_next_page,   // Transmit page
  input wire logic        tx_page_loaded  // Load pulse
);
  logic       rd_setup;
  logic       an_live;
  logic       tgl;
  logic [4:0] mss_live;
  logic [15:0] wr_lo;
  assign rd_setup = psel && !penable && !pwrite;
  assign an_live  = lp_an_able && an_enable;
  assign tgl      = tx_next_page[11];
  assign mss_live = {ms_master, local_rx_ok, remote_rx_ok, gig_fd_adv, lp_gig_hd};
  assign wr_lo    = pwdata[15:0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ======================================================================
  // Properties
  property p_exp_loc;
    rd_setup && paddr == 8'h18 |=> prdata[2] && prdata[31:5] == 27'h0;
  endproperty
  a_exp_loc: assert property (p_exp_loc) else $error("expansion fixed bits wrong");
  property p_exp_live;
    rd_setup && paddr == 8'h18 |=> prdata[3] == $past(lp_np_able) && prdata[0] == $past(an_live);
  endproperty
  a_exp_live: assert property (p_exp_live) else $error("expansion live bits wrong");
  property p_npr_rsv;
    rd_setup && paddr == 8'h20 |=> !prdata[14] && prdata[31:16] == 16'h0;
  endproperty
  a_npr_rsv: assert property (p_npr_rsv) else $error("received page reserved bit set");
  property p_mss_live;
    rd_setup && paddr == 8'h28 |=> prdata[14:10] == $past(mss_live) && prdata[9:8] == 2'h0;
  endproperty
  a_mss_live: assert property (p_mss_live) else $error("status level bits wrong");
  property p_iac_zero;
    rd_setup && paddr == 8'h34 |=> prdata == 32'h0;
  endproperty
  a_iac_zero: assert property (p_iac_zero) else $error("control register not write-only");
  property p_unmapped;
    rd_setup && paddr == 8'h3C |=> pready && pslverr && prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_tog;
    tx_page_sent |=> tgl != $past(tgl);
  endproperty
  a_tog: assert property (p_tog) else $error("toggle did not flip");
  property p_npt_wr;
    psel && penable && pwrite && pready && paddr == 8'h1C && pstrb == 4'hF
      |=> tx_page_loaded && (tx_next_page & 16'hB7FF) == ($past(wr_lo) & 16'hB7FF) && !tx_next_page[14];
  endproperty
  a_npt_wr: assert property (p_npt_wr) else $error("transmit page write wrong");
endmodule

bind anmr_regs anmr_regs_chk i_anmr_regs_chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .lp_np_able, .an_enable, .lp_an_able, .tx_page_sent, .ms_master, .local_rx_ok, .remote_rx_ok,
  .gig_fd_adv, .lp_gig_hd, .tx_next_page, .tx_page_loaded
);

//--- autoneg_nextpage_mmd_regs_bench.sv
// Self-checking bench for the autoneg next-page and indirect-access register bank
`timescale 1ns/1ps
module autoneg_nextpage_mmd_regs_bench;
  typedef struct packed {logic w; logic [7:0] a; logic [15:0] d; logic [3:0] s;} anmr_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        pready, pslverr, tx_page_loaded;
  logic        pd_fault_det = 1'b0, rx_page_valid = 1'b0, ms_fault_det = 1'b0, idle_err = 1'b0;
  logic        tx_page_sent = 1'b0, lp_np_able = 1'b1, an_enable = 1'b1, lp_an_able = 1'b1;
  logic        ms_master = 1'b1, local_rx_ok = 1'b1, remote_rx_ok = 1'b0, gig_fd_adv = 1'b1;
  logic        lp_gig_hd = 1'b0;
  logic [15:0] rx_page_data = 16'h0, tx_next_page;
  logic [31:0] rd;
  logic        er;
  int          err_total = 0, samples_checked = 0;
  anmr_row_t   rows [$] = '{
    '{1'b0, 8'h18, 16'h000D, 4'hF}, '{1'b0, 8'h1C, 16'h0001, 4'hF},
    '{1'b0, 8'h20, 16'h0000, 4'hF}, '{1'b0, 8'h28, 16'h6800, 4'hF},
    '{1'b0, 8'h3C, 16'h0000, 4'hF}, '{1'b1, 8'h3C, 16'hFFFF, 4'hF},
    '{1'b1, 8'h18, 16'hFFFF, 4'hF}, '{1'b0, 8'h18, 16'h000D, 4'hF},
    '{1'b1, 8'h1C, 16'hFFFF, 4'hF}, '{1'b0, 8'h1C, 16'hB7FF, 4'hF},
    '{1'b1, 8'h1C, 16'h2ABC, 4'hF}, '{1'b0, 8'h1C, 16'h22BC, 4'hF},
    '{1'b1, 8'h1C, 16'hFFFF, 4'h1}, '{1'b0, 8'h1C, 16'h22FF, 4'hF},
    '{1'b1, 8'h34, 16'h0003, 4'hF}, '{1'b0, 8'h34, 16'h0000, 4'hF},
    '{1'b1, 8'h38, 16'h0005, 4'hF}, '{1'b0, 8'h38, 16'h0005, 4'hF},
    '{1'b1, 8'h34, 16'h4003, 4'hF}, '{1'b1, 8'h38, 16'h1234, 4'hF},
    '{1'b0, 8'h38, 16'h1234, 4'hF}, '{1'b0, 8'h38, 16'h1234, 4'hF},
    '{1'b1, 8'h34, 16'h8003, 4'hF}, '{1'b0, 8'h38, 16'h1234, 4'hF},
    '{1'b0, 8'h38, 16'h0000, 4'hF}, '{1'b1, 8'h38, 16'hAAAA, 4'hF},
    '{1'b1, 8'h34, 16'h0003, 4'hF}, '{1'b0, 8'h38, 16'h0008, 4'hF},
    '{1'b1, 8'h34, 16'hC003, 4'hF}, '{1'b1, 8'h38, 16'h5555, 4'hF},
    '{1'b0, 8'h38, 16'h0000, 4'hF}, '{1'b1, 8'h34, 16'h0003, 4'hF},
    '{1'b0, 8'h38, 16'h0009, 4'hF}, '{1'b1, 8'h34, 16'h0007, 4'hF},
    '{1'b0, 8'h38, 16'h0000, 4'hF}, '{1'b1, 8'h34, 16'h4002, 4'hF},
    '{1'b1, 8'h38, 16'hFFFF, 4'hF}, '{1'b0, 8'h38, 16'h0000, 4'hF},
    '{1'b1, 8'h34, 16'h0001, 4'hF}, '{1'b1, 8'h38, 16'h0007, 4'hF},
    '{1'b0, 8'h38, 16'h0007, 4'hF}, '{1'b1, 8'h34, 16'h4001, 4'hF},
    '{1'b0, 8'h38, 16'h0000, 4'hF}, '{1'b1, 8'h34, 16'h0003, 4'hF},
    '{1'b1, 8'h38, 16'h0007, 4'hF}, '{1'b1, 8'h34, 16'h4003, 4'hF},
    '{1'b0, 8'h38, 16'hAAAA, 4'hF}};

  anmr_regs i_anmr_regs
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .pd_fault_det, .lp_np_able, .an_enable, .lp_an_able, .rx_page_valid, .rx_page_data, .tx_page_sent,
    .ms_fault_det, .ms_master, .local_rx_ok, .remote_rx_ok, .gig_fd_adv, .lp_gig_hd, .idle_err,
    .tx_next_page, .tx_page_loaded
  );

  always #25 pclk = ~pclk;

  // ======================================================================
  // Tasks
  task automatic results();
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      err_total++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000, 4'hF);
    chk_word("prdata", {16'h0000, e}, rd);
  endtask

  task automatic events(input logic v);
    pd_fault_det <= v;
    rx_page_valid <= v;
    ms_fault_det <= v;
    idle_err <= v;
  endtask

  // ======================================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    chk_word("tx_next_page", 32'h00000001, {16'h0000, tx_next_page});
    chk_bit("pready", 1'b0, pready);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rows[i].s);
      chk_bit("pslverr", rows[i].a == 8'h3C, er);
      if (!rows[i].w)
        chk_word("prdata", {16'h0000, rows[i].d}, rd);
    end
    // Sticky flags and idle count; the first read clears them and a second read shows them cleared
    @(posedge pclk);
    events(1'b1);
    rx_page_data <= 16'hFFFF;
    an_enable <= 1'b0;
    remote_rx_ok <= 1'b1;
    lp_gig_hd <= 1'b1;
    repeat (3) @(posedge pclk);
    events(1'b0);
    rd_chk(8'h18, 16'h001E);
    rd_chk(8'h18, 16'h000C);
    rd_chk(8'h20, 16'hBFFF);
    rd_chk(8'h28, 16'hFC03);
    rd_chk(8'h28, 16'h7C00);
    @(posedge pclk);
    tx_page_sent <= 1'b1;
    @(posedge pclk);
    tx_page_sent <= 1'b0;
    rd_chk(8'h1C, 16'h2AFF);
    apb(1'b1, 8'h1C, 16'h0000, 4'hF);
    @(posedge pclk);
    chk_bit("tx_page_loaded", 1'b1, tx_page_loaded);
    chk_word("tx_next_page", 32'h00000800, {16'h0000, tx_next_page});
    @(posedge pclk);
    chk_bit("tx_page_loaded", 1'b0, tx_page_loaded);
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_word("tx_next_page", 32'h00000001, {16'h0000, tx_next_page});
    presetn <= 1'b1;
    rd_chk(8'h1C, 16'h0001);
    rd_chk(8'h18, 16'h000C);
    apb(1'b1, 8'h34, 16'h0003, 4'hF);
    rd_chk(8'h38, 16'h0000);
    results();
  end
endmodule
